// ==== rtl/fhr_responder.sv ====
// Command interpreter of the field device responder
`timescale 1ns/1ns
module fhr_responder #(
  parameter int BLINK_CYCLES = fhr_pkg::BLINK_CYC,
  parameter int HEART_CYCLES = fhr_pkg::HEART_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hart_sel,
  input wire logic loop_temp_sel,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [31:0] cmd_data,
  input wire logic pv_sample,
  input wire logic [15:0] flow_in,
  input wire logic [15:0] total_in,
  input wire logic [15:0] temp_in,
  input wire logic [15:0] hours_in,
  input wire logic [7:0] cond0,
  input wire logic [7:0] cond1,
  input wire logic sensor_err,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_code,
  output logic [7:0] rsp_nbytes,
  output logic [7:0] dev_status,
  output logic [7:0] ext_status,
  output logic [7:0] spec_status0,
  output logic [7:0] spec_status1,
  output logic [15:0] rsp_pv,
  output logic [15:0] rsp_sv,
  output logic [15:0] rsp_tv,
  output logic [15:0] rsp_qv,
  output logic [15:0] loop_value,
  output logic fixed_mode,
  output logic [15:0] damping,
  output logic [15:0] urv,
  output logic [15:0] lrv,
  output logic [7:0] pv_units,
  output logic [15:0] trim_min,
  output logic [15:0] trim_max,
  output logic [7:0] preambles,
  output logic receive_indicator,
  output logic transmit_indicator,
  output logic heartbeat_indicator
);
  import fhr_pkg::*;

  fhr_state_t state_reg;
  logic [7:0] code_reg;
  logic [31:0] data_reg;
  logic hart_en_reg;
  logic latched_reg;
  logic powerup_reg;
  logic cfg_chg_reg;
  logic [15:0] fixed_val_reg;
  logic [15:0] damped_reg;
  logic [15:0] prim;
  logic signed [16:0] diff;
  logic [7:0] st0;
  logic [7:0] st1;
  logic known;
  logic [31:0] rx_cnt_reg;
  logic [31:0] tx_cnt_reg;
  logic [31:0] hb_cnt_reg;

  // HART selection caught once after reset release
  always_ff @(posedge clk) begin
    if (!nrst) begin
      latched_reg <= 1'b0;
      hart_en_reg <= 1'b0;
    end else if (!latched_reg) begin
      latched_reg <= 1'b1;
      hart_en_reg <= hart_sel;
    end
  end

  // Recognised command set
  always_comb begin
    unique case (code_reg)
      CMD_DAMP, CMD_RANGE, CMD_SET_URV, CMD_SET_LRV, CMD_CLR_CFG, CMD_FIXED,
      CMD_UNITS, CMD_TRIM_MIN, CMD_TRIM_MAX, CMD_ADD_STAT, CMD_PREAMB: known = 1'b1;
      default: known = (code_reg <= CMD_UNIV_LAST);
    endcase
  end

  // Request sequencer
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= ST_IDLE;
      cmd_ready <= 1'b0;
      code_reg <= 8'h00;
      data_reg <= 32'h0000_0000;
      rsp_valid <= 1'b0;
      rsp_code <= RC_OK;
      rsp_nbytes <= 8'h00;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          cmd_ready <= hart_en_reg;
          if (cmd_valid && cmd_ready) begin
            code_reg <= cmd_code;
            data_reg <= cmd_data;
            cmd_ready <= 1'b0;
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          rsp_valid <= 1'b1;
          rsp_code <= known ? RC_OK : RC_NOT_IMPL;
          rsp_nbytes <= (code_reg == CMD_ADD_STAT) ? ADD_STAT_BYTES : 8'h00;
          state_reg <= ST_ANS;
        end
        ST_ANS: begin
          rsp_valid <= 1'b0;
          cmd_ready <= 1'b1;
          state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Configuration writes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      damping <= DAMP_RST;
      urv <= URV_RST;
      lrv <= LRV_RST;
      pv_units <= UNITS_RST;
      trim_min <= TRIM_RST;
      trim_max <= TRIM_RST;
      preambles <= PREAMB_RST;
      cfg_chg_reg <= 1'b0;
    end else if (state_reg == ST_EXEC) begin
      unique case (code_reg)
        CMD_DAMP: begin
          damping <= data_reg[15:0];
          cfg_chg_reg <= 1'b1;
        end
        CMD_RANGE: begin
          urv <= data_reg[31:16];
          lrv <= data_reg[15:0];
          cfg_chg_reg <= 1'b1;
        end
        CMD_SET_URV: begin
          urv <= damped_reg;
          cfg_chg_reg <= 1'b1;
        end
        CMD_SET_LRV: begin
          lrv <= damped_reg;
          cfg_chg_reg <= 1'b1;
        end
        CMD_CLR_CFG: cfg_chg_reg <= 1'b0;
        CMD_UNITS: begin
          pv_units <= data_reg[7:0];
          cfg_chg_reg <= 1'b1;
        end
        CMD_TRIM_MIN: trim_min <= data_reg[15:0];
        CMD_TRIM_MAX: trim_max <= data_reg[15:0];
        CMD_PREAMB: preambles <= data_reg[7:0];
        default: cfg_chg_reg <= cfg_chg_reg;
      endcase
    end
  end

  // Fixed current mode
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fixed_mode <= 1'b0;
      fixed_val_reg <= 16'h0000;
    end else if (state_reg == ST_EXEC && code_reg == CMD_FIXED) begin
      fixed_mode <= (data_reg[15:0] != 16'h0000);
      fixed_val_reg <= data_reg[15:0];
    end
  end

  // Damped primary variable
  assign prim = loop_temp_sel ? temp_in : flow_in;
  assign diff = $signed({1'b0, prim}) - $signed({1'b0, damped_reg});
  always_ff @(posedge clk) begin
    if (!nrst) begin
      damped_reg <= 16'h0000;
    end else if (pv_sample) begin
      damped_reg <= damped_reg + 16'(diff >>> damping[3:0]);
    end
  end

  // Dynamic variables and loop output
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rsp_pv <= 16'h0000;
      rsp_sv <= 16'h0000;
      rsp_tv <= 16'h0000;
      rsp_qv <= 16'h0000;
      loop_value <= 16'h0000;
    end else begin
      rsp_pv <= damped_reg;
      rsp_sv <= total_in;
      rsp_tv <= temp_in;
      rsp_qv <= hours_in;
      loop_value <= fixed_mode ? fixed_val_reg : damped_reg;
    end
  end

  // Status bytes follow conditions, except byte 0 bit 0 (power-up flag) and byte 1 bits 5:3 (held zero)
  assign st0 = {cond0[7:1], powerup_reg};
  assign st1 = {cond1[7:6], 3'b000, cond1[2:0]};
  always_ff @(posedge clk) begin
    if (!nrst) begin
      powerup_reg <= 1'b1;
    end else if (state_reg == ST_EXEC && code_reg == CMD_ADD_STAT) begin
      powerup_reg <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      spec_status0 <= 8'h00;
      spec_status1 <= 8'h00;
      dev_status <= 8'h00;
      ext_status <= 8'h00;
    end else begin
      spec_status0 <= st0;
      spec_status1 <= st1;
      dev_status <= 8'h00;
      dev_status[DS_MORE] <= (st0[7:1] != 7'h00) || (st1 != 8'h00) || sensor_err;
      dev_status[DS_FIXED] <= fixed_mode;
      dev_status[DS_CFG_CHG] <= cfg_chg_reg;
      ext_status <= 8'h00;
      ext_status[XS_SENSOR] <= sensor_err;
      ext_status[XS_VAR_ALERT] <= (damped_reg > urv) || (damped_reg < lrv);
    end
  end

  // Indicator blink and heartbeat
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rx_cnt_reg <= 32'h0000_0000;
      receive_indicator <= 1'b0;
    end else if (cmd_valid && cmd_ready) begin
      rx_cnt_reg <= 32'(BLINK_CYCLES);
      receive_indicator <= 1'b1;
    end else if (rx_cnt_reg != 32'h0000_0000) begin
      rx_cnt_reg <= rx_cnt_reg - 32'h0000_0001;
      receive_indicator <= (rx_cnt_reg != 32'h0000_0001);
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tx_cnt_reg <= 32'h0000_0000;
      transmit_indicator <= 1'b0;
    end else if (state_reg == ST_EXEC) begin
      tx_cnt_reg <= 32'(BLINK_CYCLES);
      transmit_indicator <= 1'b1;
    end else if (tx_cnt_reg != 32'h0000_0000) begin
      tx_cnt_reg <= tx_cnt_reg - 32'h0000_0001;
      transmit_indicator <= (tx_cnt_reg != 32'h0000_0001);
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      hb_cnt_reg <= 32'h0000_0000;
      heartbeat_indicator <= 1'b0;
    end else if (hb_cnt_reg >= 32'(HEART_CYCLES - 1)) begin
      hb_cnt_reg <= 32'h0000_0000;
      heartbeat_indicator <= !heartbeat_indicator;
    end else begin
      hb_cnt_reg <= hb_cnt_reg + 32'h0000_0001;
    end
  end

  // Checks
  property p_more;
    @(posedge clk) disable iff (!nrst) sensor_err |=> dev_status[DS_MORE];
  endproperty
  a_more: assert property (p_more) else $error("more status not set");
  property p_sens;
    @(posedge clk) disable iff (!nrst) sensor_err |=> ext_status[XS_SENSOR];
  endproperty
  a_sens: assert property (p_sens) else $error("sensor bit not set");
  property p_alert;
    @(posedge clk) disable iff (!nrst) (damped_reg > urv) |=> ext_status[XS_VAR_ALERT];
  endproperty
  a_alert: assert property (p_alert) else $error("variable alert missing");
  property p_two;
    @(posedge clk) disable iff (!nrst)
      (state_reg == ST_EXEC && code_reg == CMD_ADD_STAT) |=> rsp_valid && rsp_nbytes == 8'h02;
  endproperty
  a_two: assert property (p_two) else $error("status byte count wrong");
  property p_follow;
    @(posedge clk) disable iff (!nrst)
      nrst |=> spec_status1 == {$past(cond1[7:6]), 3'b000, $past(cond1[2:0])};
  endproperty
  a_follow: assert property (p_follow) else $error("status byte 1 stale");
  property p_only_req;
    @(posedge clk) disable iff (!nrst) $rose(rsp_valid) |-> $past(state_reg, 1) == ST_EXEC;
  endproperty
  a_only_req: assert property (p_only_req) else $error("unsolicited answer");
  property p_devspec;
    @(posedge clk) disable iff (!nrst)
      (cmd_valid && cmd_ready && cmd_code[7]) |-> ##2 rsp_valid && rsp_code == RC_NOT_IMPL;
  endproperty
  a_devspec: assert property (p_devspec) else $error("device command accepted");
  property p_fixed;
    @(posedge clk) disable iff (!nrst) fixed_mode |=> loop_value == $past(fixed_val_reg);
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed current ignored");
  property p_sel;
    @(posedge clk) disable iff (!nrst) !hart_en_reg && latched_reg |-> !cmd_ready;
  endproperty
  a_sel: assert property (p_sel) else $error("responder active unselected");
  property p_rx;
    @(posedge clk) disable iff (!nrst) (cmd_valid && cmd_ready) |=> receive_indicator;
  endproperty
  a_rx: assert property (p_rx) else $error("receive blink missing");
  property p_keep;
    @(posedge clk) disable iff (!nrst)
      (state_reg == ST_EXEC && !known) |=> $stable(damping) && $stable(urv) && rsp_code == RC_NOT_IMPL;
  endproperty
  a_keep: assert property (p_keep) else $error("unknown command changed state");
  c_add: cover property (@(posedge clk) rsp_valid && rsp_nbytes == 8'h02);
  c_fix: cover property (@(posedge clk) $rose(fixed_mode));
  c_nimp: cover property (@(posedge clk) rsp_valid && rsp_code == RC_NOT_IMPL);
  c_alert: cover property (@(posedge clk) ext_status[XS_VAR_ALERT]);
endmodule

// ==== rtl/fhr_pkg.sv ====
// Package of constants for the field device responder
package fhr_pkg;
  // Command numbers
  localparam logic [7:0] CMD_UNIV_LAST = 8'h16;
  localparam logic [7:0] CMD_DAMP = 8'h22;
  localparam logic [7:0] CMD_RANGE = 8'h23;
  localparam logic [7:0] CMD_SET_URV = 8'h24;
  localparam logic [7:0] CMD_SET_LRV = 8'h25;
  localparam logic [7:0] CMD_CLR_CFG = 8'h26;
  localparam logic [7:0] CMD_FIXED = 8'h28;
  localparam logic [7:0] CMD_UNITS = 8'h2C;
  localparam logic [7:0] CMD_TRIM_MIN = 8'h2D;
  localparam logic [7:0] CMD_TRIM_MAX = 8'h2E;
  localparam logic [7:0] CMD_ADD_STAT = 8'h30;
  localparam logic [7:0] CMD_PREAMB = 8'h3B;
  // Response codes
  localparam logic [7:0] RC_OK = 8'h00;
  localparam logic [7:0] RC_NOT_IMPL = 8'h40;
  // Device status field positions
  localparam int DS_FIXED = 3;
  localparam int DS_MORE = 4;
  localparam int DS_CFG_CHG = 6;
  // Extended status field positions
  localparam int XS_SENSOR = 0;
  localparam int XS_VAR_ALERT = 1;
  // Additional status byte count
  localparam logic [7:0] ADD_STAT_BYTES = 8'h02;
  // Reset values
  localparam logic [15:0] DAMP_RST = 16'h0000;
  localparam logic [15:0] URV_RST = 16'hFFFF;
  localparam logic [15:0] LRV_RST = 16'h0000;
  localparam logic [7:0] UNITS_RST = 8'h00;
  localparam logic [7:0] PREAMB_RST = 8'h05;
  localparam logic [15:0] TRIM_RST = 16'h0000;
  // Timing
  localparam int CLK_HZ = 20_000_000;
  localparam int BLINK_MS = 20;
  localparam int HEART_MS = 500;
  localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
  localparam int HEART_CYC = HEART_MS * (CLK_HZ / 1000);
  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_ANS = 2'b11
  } fhr_state_t;
endpackage

// ==== test/fhr_master.sv ====
// Master-side request model for the responder
`timescale 1ns/1ns
module fhr_master (
  input wire logic clk,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_code,
  input wire logic [7:0] rsp_nbytes,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic [31:0] cmd_data
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    cmd_data = 32'h0000_0000;
  end
  // Held until taken, then payload lines scrambled
  task automatic send(input logic [7:0] c, input logic [31:0] d, input int stall,
    output logic [7:0] rc, output logic [7:0] nb, output int lat);
    int n;
    rc = 8'hxx;
    nb = 8'hxx;
    lat = -1;
    n = 0;
    repeat (stall + 1) @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_data <= d;
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 50);
    cmd_valid <= 1'b0;
    cmd_code <= ~c;
    cmd_data <= ~d;
    // Latency counted in edges after the taking edge
    for (n = 1; n <= 10 && lat < 0; n++) begin
      @(posedge clk);
      if (rsp_valid === 1'b1) begin
        rc = rsp_code;
        nb = rsp_nbytes;
        lat = n;
      end
    end
    #1;
  endtask
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the responder
`timescale 1ns/1ns
module testbench;
  import fhr_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, hart_sel = 1'b1, loop_temp_sel = 1'b0;
  logic pv_sample = 1'b0, sensor_err = 1'b0;
  logic [15:0] flow_in = 16'h0000, total_in = 16'h0000, temp_in = 16'h0000;
  logic [15:0] hours_in = 16'h0000;
  logic [7:0] cond0 = 8'h00, cond1 = 8'h00, rc, nb, cmd_code, rsp_code, rsp_nbytes;
  logic [7:0] dev_status, ext_status, spec_status0, spec_status1, pv_units, preambles;
  logic [15:0] rsp_pv, rsp_sv, rsp_tv, rsp_qv, loop_value, damping, urv, lrv;
  logic [15:0] trim_min, trim_max;
  logic [31:0] cmd_data;
  logic cmd_valid, cmd_ready, rsp_valid, fixed_mode, hb, rsp_seen;
  logic receive_indicator, transmit_indicator, heartbeat_indicator;
  logic [7:0] bad [6] = '{8'h80, 8'h27, 8'h6D, 8'h71, 8'hFF, 8'h17};
  int fail_count = 0, cmp_count = 0, lat, i, n;
  initial forever #25 clk = ~clk;
  fhr_responder #(.BLINK_CYCLES(4), .HEART_CYCLES(8)) u_fhr_responder (.clk, .nrst,
    .hart_sel, .loop_temp_sel, .cmd_valid, .cmd_code, .cmd_data, .pv_sample, .flow_in,
    .total_in, .temp_in, .hours_in, .cond0, .cond1, .sensor_err, .cmd_ready, .rsp_valid,
    .rsp_code, .rsp_nbytes, .dev_status, .ext_status, .spec_status0, .spec_status1,
    .rsp_pv, .rsp_sv, .rsp_tv, .rsp_qv, .loop_value, .fixed_mode, .damping, .urv, .lrv,
    .pv_units, .trim_min, .trim_max, .preambles, .receive_indicator, .transmit_indicator,
    .heartbeat_indicator);
  fhr_master u_fhr_master (.clk, .cmd_ready, .rsp_valid, .rsp_code, .rsp_nbytes,
    .cmd_valid, .cmd_code, .cmd_data);
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic [31:0] d, input logic [7:0] e);
    u_fhr_master.send(c, d, 0, rc, nb, lat);
    chk("rsp_code", 16'(e), 16'(rc));
    chk("latency", 16'h0002, lat[15:0]);
    chk("rsp bytes", 16'((c == CMD_ADD_STAT) ? ADD_STAT_BYTES : 8'h00), 16'(nb));
    chk("indicators", 16'h0003, 16'({receive_indicator, transmit_indicator}));
  endtask
  task automatic rst(input logic hs);
    @(posedge clk);
    nrst <= 1'b0;
    hart_sel <= hs;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic drive(input logic [7:0] a, input logic [7:0] b, input logic s);
    @(posedge clk);
    cond0 <= a;
    cond1 <= b;
    sensor_err <= s;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic strobe(input logic [15:0] f, input logic [15:0] t, input logic [15:0] g);
    @(posedge clk);
    flow_in <= f;
    total_in <= t;
    temp_in <= g;
    hours_in <= 16'h0077;
    pv_sample <= 1'b1;
    @(posedge clk);
    pv_sample <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    $display("watchdog expired");
    fail_count++;
    end_sim();
  end
  initial begin
    rst(1'b0);
    chk("ready unselected", 16'h0000, 16'(cmd_ready));
    rst(1'b1);
    chk("urv", URV_RST, urv);
    chk("preambles", 16'(PREAMB_RST), 16'(preambles));
    chk("power-up", 16'h0001, 16'(spec_status0));
    @(posedge clk);
    hart_sel <= 1'b0;
    cmd(CMD_DAMP, 32'h0000_0003, RC_OK);
    chk("damping", 16'h0003, damping);
    cmd(CMD_RANGE, 32'h1000_0100, RC_OK);
    chk("urv", 16'h1000, urv);
    chk("lrv", 16'h0100, lrv);
    cmd(CMD_UNITS, 32'h0000_0039, RC_OK);
    chk("units", 16'h0039, 16'(pv_units));
    cmd(CMD_TRIM_MIN, 32'h0000_0123, RC_OK);
    chk("trim min", 16'h0123, trim_min);
    cmd(CMD_TRIM_MAX, 32'h0000_0F00, RC_OK);
    chk("trim max", 16'h0F00, trim_max);
    cmd(CMD_PREAMB, 32'h0000_0014, RC_OK);
    chk("preambles", 16'h0014, 16'(preambles));
    chk("cfg changed", 16'h0001, 16'(dev_status[DS_CFG_CHG]));
    cmd(CMD_CLR_CFG, 32'h0000_0000, RC_OK);
    chk("cfg changed", 16'h0000, 16'(dev_status[DS_CFG_CHG]));
    cmd(8'h00, 32'h0000_0000, RC_OK);
    for (i = 0; i < 6; i++) begin
      cmd(bad[i], 32'hFFFF_FFFF, RC_NOT_IMPL);
      chk("damping kept", 16'h0003, damping);
      chk("cfg kept", 16'h0000, 16'(dev_status[DS_CFG_CHG]));
    end
    $display("command test done");
    cmd(CMD_FIXED, 32'h0000_4321, RC_OK);
    chk("fixed", 16'h0003, 16'({fixed_mode, dev_status[DS_FIXED]}));
    chk("loop value", 16'h4321, loop_value);
    cmd(CMD_FIXED, 32'h0000_0000, RC_OK);
    chk("fixed off", 16'h0000, 16'(fixed_mode));
    cmd(CMD_FIXED, 32'h0000_0001, RC_OK);
    rst(1'b1);
    chk("fixed reset", 16'h0000, 16'(fixed_mode));
    $display("fixed mode test done");
    u_fhr_master.send(CMD_ADD_STAT, 32'h0000_0000, 3, rc, nb, lat);
    chk("add status bytes", 16'h0002, 16'(nb));
    chk("add status code", 16'(RC_OK), 16'(rc));
    chk("add status latency", 16'h0002, lat[15:0]);
    for (i = 0; i < 8; i++) begin
      drive(8'h01 << i, 8'h01 << i, 1'b0);
      chk("byte0", 16'(8'hFE & (8'h01 << i)), 16'(spec_status0));
      chk("byte1", 16'(8'hC7 & (8'h01 << i)), 16'(spec_status1));
      chk("more", 16'h0001, 16'(dev_status[DS_MORE]));
    end
    drive(8'h00, 8'h00, 1'b1);
    chk("sensor", 16'h0003, 16'({dev_status[DS_MORE], ext_status[XS_SENSOR]}));
    drive(8'h00, 8'h00, 1'b0);
    chk("cleared", 16'h0000, {spec_status0, spec_status1});
    chk("cleared", 16'h0000, 16'({dev_status[DS_MORE], ext_status[XS_SENSOR]}));
    $display("status test done");
    cmd(CMD_RANGE, 32'h1000_0100, RC_OK);
    strobe(16'h2000, 16'h0055, 16'h0066);
    chk("pv", 16'h2000, rsp_pv);
    chk("sv tv", 16'h5566, {rsp_sv[7:0], rsp_tv[7:0]});
    chk("qv", 16'h0077, rsp_qv);
    chk("alert", 16'h0001, 16'(ext_status[XS_VAR_ALERT]));
    strobe(16'h0800, 16'h0055, 16'h0066);
    chk("alert off", 16'h0000, 16'(ext_status[XS_VAR_ALERT]));
    cmd(CMD_SET_URV, 32'h0000_0000, RC_OK);
    chk("urv from pv", 16'h0800, urv);
    cmd(CMD_SET_LRV, 32'h0000_0000, RC_OK);
    chk("lrv from pv", 16'h0800, lrv);
    cmd(CMD_DAMP, 32'h0000_0004, RC_OK);
    strobe(16'h1800, 16'h0099, 16'h0066);
    chk("pv damped", 16'h0900, rsp_pv);
    chk("loop damped", 16'h0900, loop_value);
    chk("sv undamped", 16'h0099, rsp_sv);
    cmd(CMD_DAMP, 32'h0000_0000, RC_OK);
    @(posedge clk);
    loop_temp_sel <= 1'b1;
    strobe(16'h1800, 16'h0099, 16'h0333);
    chk("pv temp", 16'h0333, rsp_pv);
    $display("variable test done");
    hb = heartbeat_indicator;
    n = 0;
    rsp_seen = 1'b0;
    repeat (20) begin
      @(posedge clk);
      rsp_seen = rsp_seen | rsp_valid | transmit_indicator;
      if (heartbeat_indicator !== hb)
        n++;
      hb = heartbeat_indicator;
    end
    chk("heartbeat", 16'h0001, 16'(n >= 2));
    chk("silent", 16'h0000, 16'({rsp_seen, receive_indicator}));
    $display("indicator test done");
    end_sim();
  end
endmodule
